// ===== hw/spcfg_regs.sv
// Pulse and comparator threshold configuration register bank with drive.
`timescale 1ns/1ns
`default_nettype none
module spcfg_regs #(
    parameter int unsigned STEP_CYC = spcfg_pkg::DUR_STEP_CYC
) (
    // Clock and reset.
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // Register access from the serial host port.
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [spcfg_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [spcfg_pkg::DATA_W-1:0]  reg_wdata,
    output logic      [spcfg_pkg::DATA_W-1:0]  reg_rdata,
    output logic                               reg_hit,
    // Pulse request from the sequencer.
    input  wire logic                          pulse_start,
    // Analog drive controls and edge interrupt enables.
    output logic                               pulse_active,
    output logic      [spcfg_pkg::NUM_IN-1:0]  pulse_drive,
    output logic      [spcfg_pkg::NUM_IN-1:0]  pulse_high_cur,
    output logic      [2*spcfg_pkg::NUM_IN-1:0] level_sel,
    output logic      [spcfg_pkg::DATA_W-1:0]  edge_int_en
);
    import spcfg_pkg::*;

    logic [PULSE_CFG_W-1:0] pulse_cfg_reg;
    logic [NUM_IN-1:0]      pulse_en_reg;
    logic [LEVEL_SEL_W-1:0] level_sel_reg;
    logic [DATA_W-1:0]      edge_en_reg;
    logic [DUR_W-1:0]       pulse_duration;
    logic [CUR_GRPS-1:0]    pulse_current_grp;
    logic                   sel_cfg;
    logic                   sel_en;
    logic                   sel_lvl;
    logic                   sel_edge;
    logic [DATA_W-1:0]      rdata_next;
    logic                   timer_busy;
    logic [NUM_IN-1:0]      high_cur_map;
    logic [2*NUM_IN-1:0]    level_map;

    assign sel_cfg  = (reg_addr == OFS_PULSE_CFG);
    assign sel_en   = (reg_addr == OFS_PULSE_EN);
    assign sel_lvl  = (reg_addr == OFS_LEVEL_SEL);
    assign sel_edge = (reg_addr == OFS_EDGE_EN);
    assign reg_hit  = sel_cfg | sel_en | sel_lvl | sel_edge;

    assign pulse_duration    = pulse_cfg_reg[DUR_LSB +: DUR_W];
    assign pulse_current_grp = pulse_cfg_reg[CUR_LSB +: CUR_GRPS];

    // Reserved bits are zero-extended on read.
    assign rdata_next =
        sel_cfg  ? DATA_W'(pulse_cfg_reg) :
        sel_en   ? pulse_en_reg :
        sel_lvl  ? DATA_W'(level_sel_reg) :
        sel_edge ? edge_en_reg : RESET_VAL;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_cfg_reg <= PULSE_CFG_W'(RESET_VAL);
            pulse_en_reg  <= RESET_VAL;
            level_sel_reg <= LEVEL_SEL_W'(RESET_VAL);
            edge_en_reg   <= RESET_VAL;
        end else if (reg_wr) begin
            if (sel_cfg) begin
                pulse_cfg_reg <= reg_wdata[PULSE_CFG_W-1:0];
            end
            if (sel_en) begin
                pulse_en_reg <= reg_wdata;
            end
            if (sel_lvl) begin
                level_sel_reg <= reg_wdata[LEVEL_SEL_W-1:0];
            end
            if (sel_edge) begin
                edge_en_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= RESET_VAL;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    spcfg_pulse_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_timer (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (pulse_start),
        .duration (pulse_duration),
        .busy     (timer_busy)
    );

    // Group current bit fans out to six inputs each, level code to four.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_map
            assign high_cur_map[gi] =
                pulse_current_grp[gi / CUR_GRP_SIZE];
            assign level_map[2*gi +: 2] =
                level_sel_reg[LVL_W*(gi / LVL_GRP_SIZE) +: LVL_W];
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_active   <= 1'b0;
            pulse_drive    <= '0;
            pulse_high_cur <= '0;
            level_sel      <= '0;
            edge_int_en    <= '0;
        end else begin
            pulse_active   <= timer_busy;
            pulse_drive    <= timer_busy ? pulse_en_reg : '0;
            pulse_high_cur <= high_cur_map;
            level_sel      <= level_map;
            edge_int_en    <= edge_en_reg;
        end
    end

    mask_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        (pulse_drive & ~$past(pulse_en_reg)) == '0)
        else $error("pulse drives a disabled input");
    no_drive_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        !pulse_active |-> pulse_drive == '0)
        else $error("drive outside pulse");
    pulse_short_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timer_busy) && pulse_duration == 3'h0 |->
        timer_busy [*8])
        else $error("pulse ended early");
    cfg_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && sel_cfg |=> pulse_cfg_reg == $past(reg_wdata[6:0]))
        else $error("pulse config not stored");
    en_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && sel_en |=> pulse_en_reg == $past(reg_wdata))
        else $error("enable mask not stored");
    grp_d_cur_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pulse_high_cur[23:18] == {6{$past(pulse_cfg_reg[3])}})
        else $error("group d current wrong");
    grp_c_cur_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pulse_high_cur[17:12] == {6{$past(pulse_cfg_reg[2])}})
        else $error("group c current wrong");
    grp_b_cur_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pulse_high_cur[11:6] == {6{$past(pulse_cfg_reg[1])}})
        else $error("group b current wrong");
    grp_a_cur_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pulse_high_cur[5:0] == {6{$past(pulse_cfg_reg[0])}})
        else $error("group a current wrong");
    lvl_f_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[47:46] == $past(level_sel_reg[11:10]))
        else $error("level f wrong");
    lvl_e_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[33:32] == $past(level_sel_reg[9:8]))
        else $error("level e wrong");
    lvl_d_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[31:30] == $past(level_sel_reg[7:6]))
        else $error("level d wrong");
    lvl_c_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[17:16] == $past(level_sel_reg[5:4]))
        else $error("level c wrong");
    lvl_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[15:14] == $past(level_sel_reg[3:2]))
        else $error("level b wrong");
    lvl_a_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[1:0] == $past(level_sel_reg[1:0]))
        else $error("level a wrong");
    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && (sel_cfg || sel_lvl) |=> reg_rdata[23:12] == 12'h000)
        else $error("reserved bits not zero");

    // Refuse a step count that the pulse counter cannot hold at code 7.
    generate
        if (STEP_CYC < 1 || STEP_CYC > 2 ** (CNT_W - DUR_W)) begin : g_bad_step
            $error("STEP_CYC out of range");
        end
    endgenerate

    // Check helpers: the duration latched at an accepted start and the
    // number of cycles the timer has been busy so far.
    localparam int unsigned LEN_W = CNT_W + 1;

    logic [DUR_W-1:0] dur_at_start_reg;
    logic [LEN_W-1:0] busy_len_reg;
    logic [LEN_W-1:0] len_exp;
    logic             start_taken;

    assign start_taken = pulse_start & ~timer_busy;
    assign len_exp     = LEN_W'((32'(dur_at_start_reg) + 32'd1) * STEP_CYC);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dur_at_start_reg <= '0;
        end else if (start_taken) begin
            dur_at_start_reg <= pulse_duration;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_len_reg <= '0;
        end else if (timer_busy) begin
            busy_len_reg <= busy_len_reg + LEN_W'(1);
        end else begin
            busy_len_reg <= '0;
        end
    end

    pulse_len_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(timer_busy) |-> busy_len_reg == len_exp)
        else $error("pulse length wrong");
    act_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pulse_active == $past(timer_busy))
        else $error("pulse active does not follow timer");
    start_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_taken |=> ##1 pulse_active)
        else $error("pulse did not start");
    drive_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
        pulse_active |-> pulse_drive == $past(pulse_en_reg))
        else $error("drive differs from mask");

    rd_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && sel_cfg |=> reg_rdata == DATA_W'($past(pulse_cfg_reg)))
        else $error("pulse config read wrong");
    rd_en_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && sel_en |=> reg_rdata == $past(pulse_en_reg))
        else $error("enable mask read wrong");
    rd_lvl_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && sel_lvl |=> reg_rdata == DATA_W'($past(level_sel_reg)))
        else $error("threshold read wrong");
    rd_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && sel_edge |=> reg_rdata == $past(edge_en_reg))
        else $error("edge enable read wrong");
    rd_unmapped_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && !reg_hit |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    cfg_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && sel_cfg |=> reg_rdata[23:7] == 17'h00000)
        else $error("config reserved bits not zero");
    rd_stands_a: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data did not hold");

    lvl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && sel_lvl |=> level_sel_reg == $past(reg_wdata[11:0]))
        else $error("threshold not stored");
    edge_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && sel_edge |=> edge_en_reg == $past(reg_wdata))
        else $error("edge enable not stored");
    wr_ignored_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && !reg_hit |=>
        $stable(pulse_cfg_reg) && $stable(pulse_en_reg) &&
        $stable(level_sel_reg) && $stable(edge_en_reg))
        else $error("unmapped write changed a register");
    edge_out_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 edge_int_en == $past(edge_en_reg))
        else $error("edge enable output wrong");

    // Whole-group checks: every input of a group carries the group code.
    lvl_f_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[47:40] == {4{$past(level_sel_reg[11:10])}})
        else $error("level group f wrong");
    lvl_e_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[39:32] == {4{$past(level_sel_reg[9:8])}})
        else $error("level group e wrong");
    lvl_d_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[31:24] == {4{$past(level_sel_reg[7:6])}})
        else $error("level group d wrong");
    lvl_c_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[23:16] == {4{$past(level_sel_reg[5:4])}})
        else $error("level group c wrong");
    lvl_b_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[15:8] == {4{$past(level_sel_reg[3:2])}})
        else $error("level group b wrong");
    lvl_a_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 level_sel[7:0] == {4{$past(level_sel_reg[1:0])}})
        else $error("level group a wrong");

    // Drive, active, level and edge enable outputs stay quiet while reset is held.
    rst_drive_a: assert property (@(posedge clk_sys)
        rst |-> pulse_drive == '0 && !pulse_active)
        else $error("drive during reset");
    rst_cfg_out_a: assert property (@(posedge clk_sys)
        rst |-> level_sel == '0 && edge_int_en == '0)
        else $error("outputs not cleared in reset");
endmodule : spcfg_regs
`default_nettype wire

// ===== shared/spcfg_pkg.sv
// Shared constants for the switch input pulse and threshold configuration.
package spcfg_pkg;
    localparam int unsigned ADDR_W        = 6;
    localparam int unsigned DATA_W        = 24;
    localparam int unsigned NUM_IN        = 24;
    localparam logic [5:0]  OFS_PULSE_CFG = 6'h1F;
    localparam logic [5:0]  OFS_PULSE_EN  = 6'h20;
    localparam logic [5:0]  OFS_LEVEL_SEL = 6'h21;
    localparam logic [5:0]  OFS_EDGE_EN   = 6'h22;
    localparam int unsigned DUR_LSB       = 4;
    localparam int unsigned DUR_W         = 3;
    localparam int unsigned CUR_LSB       = 0;
    localparam int unsigned CUR_GRPS      = 4;
    localparam int unsigned CUR_GRP_SIZE  = 6;
    localparam int unsigned LVL_GRPS      = 6;
    localparam int unsigned LVL_GRP_SIZE  = 4;
    localparam int unsigned LVL_W         = 2;
    localparam int unsigned PULSE_CFG_W   = 7;
    localparam int unsigned LEVEL_SEL_W   = 12;
    localparam logic [23:0] RESET_VAL     = 24'h000000;
    localparam int unsigned DUR_STEP_US   = 64;
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned DUR_STEP_CYC  = DUR_STEP_US * CLK_MHZ;
    localparam int unsigned CNT_W         = 15;
    typedef enum logic [1:0] {
        LVL_2V0,
        LVL_2V7,
        LVL_3V0,
        LVL_4V0
    } spcfg_level_e;
endpackage : spcfg_pkg

// ===== hw/spcfg_pulse_timer.sv
// Cleaning pulse duration timer counting 64 us steps.
`timescale 1ns/1ns
`default_nettype none
module spcfg_pulse_timer #(
    parameter int unsigned STEP_CYC = spcfg_pkg::DUR_STEP_CYC
) (
    // Clock and reset.
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Control.
    input  wire logic                       start,
    input  wire logic [spcfg_pkg::DUR_W-1:0] duration,
    // Status.
    output logic                            busy
);
    import spcfg_pkg::*;

    initial begin
        if (STEP_CYC < 1 || STEP_CYC > 2 ** (CNT_W - DUR_W)) begin
            $error("STEP_CYC out of range");
        end
    end

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] load_val;

    assign load_val = CNT_W'((32'(duration) + 32'd1) * STEP_CYC - 32'd1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            busy      <= 1'b0;
        end else if (start && !busy) begin
            count_reg <= load_val;
            busy      <= 1'b1;
        end else if (busy) begin
            count_reg <= count_reg - CNT_W'(1);
            busy      <= (count_reg != '0);
        end
    end
endmodule : spcfg_pulse_timer
`default_nettype wire

// ===== bench/tb_spcfg_regs.sv
// Self-checking testbench for the pulse and threshold configuration bank.
`timescale 1ns/1ns
`default_nettype none
module tb_spcfg_regs;
    import spcfg_pkg::*;
    localparam int unsigned STEP = 8;
    logic        clk_sys;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [5:0]  reg_addr;
    logic [23:0] reg_wdata;
    logic [23:0] reg_rdata;
    logic        reg_hit;
    logic        pulse_start;
    logic        pulse_active;
    logic [23:0] pulse_drive;
    logic [23:0] pulse_high_cur;
    logic [47:0] level_sel;
    logic [23:0] edge_int_en;
    int          err_count = 0;
    int          checked = 0;
    logic [11:0] lvl_tab [5] = '{12'h000, 12'h555, 12'hAAA, 12'hFFF, 12'h1B6};

    spcfg_regs #(.STEP_CYC(STEP)) i_spcfg_regs (
        .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .pulse_start(pulse_start),
        .pulse_active(pulse_active), .pulse_drive(pulse_drive),
        .pulse_high_cur(pulse_high_cur), .level_sel(level_sel),
        .edge_int_en(edge_int_en)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        @(negedge clk_sys);
        reg_rd   = 1'b1;
        reg_addr = a;
        #1 chk(48'(reg_hit), 48'(a >= 6'h1F && a <= 6'h22));
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        chk(48'(reg_rdata), 48'(exp));
    endtask : rd

    function automatic logic [47:0] lvl_exp(input logic [11:0] v);
        logic [47:0] r;
        r = '0;
        for (int n = 0; n < 24; n++) r[2*n +: 2] = v[2*(n/4) +: 2];
        return r;
    endfunction : lvl_exp

    task automatic pulse_run(input logic [2:0] d, input logic [23:0] m);
        int len;
        int i;
        len = 0;
        wr(OFS_PULSE_CFG, {17'h0, d, 4'hF});
        wr(OFS_PULSE_EN, m);
        @(negedge clk_sys);
        pulse_start = 1'b1;
        @(negedge clk_sys);
        pulse_start = 1'b0;
        for (i = 0; i < 400; i++) begin
            @(negedge clk_sys);
            if (pulse_active === 1'b1) begin
                len++;
                chk(48'(pulse_drive), 48'(m));
                chk(48'(pulse_high_cur), 48'hFFFFFF);
                pulse_start = (len == 3);
            end else if (len > 0) begin
                break;
            end
        end
        if (i == 400) begin
            err_count++;
            finish_test();
        end
        chk(48'(len), 48'((d + 1) * STEP));
        chk(48'(pulse_drive), 48'h0);
        $display("pulse test with duration code %0d done", d);
    endtask : pulse_run

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
        pulse_start = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        rd(OFS_PULSE_CFG, 24'h000000);
        rd(OFS_PULSE_EN, 24'h000000);
        rd(OFS_LEVEL_SEL, 24'h000000);
        rd(OFS_EDGE_EN, 24'h000000);
        chk(level_sel, 48'h0);
        $display("reset value test done");
        wr(OFS_PULSE_CFG, 24'hFFFFFF);
        rd(OFS_PULSE_CFG, 24'h00007F);
        wr(OFS_PULSE_EN, 24'hFFFFFF);
        rd(OFS_PULSE_EN, 24'hFFFFFF);
        wr(OFS_LEVEL_SEL, 24'hFFFFFF);
        rd(OFS_LEVEL_SEL, 24'h000FFF);
        wr(OFS_EDGE_EN, 24'hA5C35A);
        rd(OFS_EDGE_EN, 24'hA5C35A);
        chk(48'(edge_int_en), 48'hA5C35A);
        wr(6'h23, 24'h123456);
        rd(6'h23, 24'h000000);
        rd(OFS_PULSE_EN, 24'hFFFFFF);
        $display("access test done");
        for (int g = 0; g < 4; g++) begin
            wr(OFS_PULSE_CFG, 24'(1 << g));
            chk(48'(pulse_high_cur), 48'(24'h3F << (6 * g)));
        end
        $display("current group test done");
        for (int k = 0; k < 5; k++) begin
            wr(OFS_LEVEL_SEL, {12'h000, lvl_tab[k]});
            chk(level_sel, lvl_exp(lvl_tab[k]));
        end
        $display("threshold test done");
        pulse_run(3'd0, 24'hA5C3F0);
        pulse_run(3'd7, 24'h5A3C0F);
        finish_test();
    end
endmodule : tb_spcfg_regs
`default_nettype wire
